// ### verilog/scsi_io_pkg.sv
// Shared constants and types for the SCSI I/O instruction sequencer
package scsi_io_pkg;

  // Timing
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned BUS_FREE_NS = 400;
  localparam int unsigned BUS_FREE_CYC_INT = (BUS_FREE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [6:0] BUS_FREE_CYC = BUS_FREE_CYC_INT[6:0];

  // Register byte offsets
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_NEXT = 8'h04;
  localparam logic [7:0] ADDR_DSB = 8'h08;
  localparam logic [7:0] ADDR_DSP = 8'h0C;
  localparam logic [7:0] ADDR_OWNID = 8'h10;
  localparam logic [7:0] ADDR_CTRL0 = 8'h14;
  localparam logic [7:0] ADDR_CTRL3 = 8'h18;
  localparam logic [7:0] ADDR_SYNC_TRANSFER_REGISTER = 8'h1C;
  localparam logic [7:0] ADDR_OCL = 8'h20;
  localparam logic [7:0] ADDR_INTERRUPT_STATUS_REGISTER = 8'h24;

  // Instruction fields
  localparam int OPC_HI = 29;
  localparam int OPC_LO = 27;
  localparam int REL_BIT = 26;
  localparam int TBL_BIT = 25;
  localparam int SELATN_BIT = 24;
  localparam int ID_HI = 18;
  localparam int ID_LO = 16;
  localparam int CARRY_BIT = 10;
  localparam int TGT_BIT = 9;
  localparam int ACK_BIT = 6;
  localparam int ATN_BIT = 3;
  localparam int OFS_HI = 23;

  // Control register zero target bit, status bits
  localparam int CTRL0_TGT = 0;
  localparam int ST_SIGNAL_PROCESS_BIT = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_ILLEGAL = 2;
  localparam int ST_CARRY = 3;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_ID = 3'h0;

  typedef enum logic [2:0] {
    OP_SEL = 3'h0,
    OP_DISC = 3'h1,
    OP_WAIT = 3'h2,
    OP_SET = 3'h3,
    OP_CLR = 3'h4
  } opcode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DECODE = 3'b001,
    ST_TABLE = 3'b011,
    ST_RUN = 3'b010,
    ST_DONE = 3'b110
  } seq_state_t;

  typedef struct packed {
    logic arb_won;
    logic selected;
    logic reselected;
    logic busy_line;
    logic sel_line;
    logic disc_msg;
    logic sel_done;
  } scsi_in_t;

  typedef struct packed {
    logic arb_req;
    logic [2:0] arb_id;
    logic sel_start;
    logic [2:0] sel_id;
    logic attention_line;
    logic acknowledge_line;
    logic release_bus;
  } scsi_out_t;

endpackage : scsi_io_pkg

// ### verilog/scsi_io_instruction_sequencer.sv
// I/O class instruction decoder and sequencer with APB register access
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module scsi_io_instruction_sequencer
  import scsi_io_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Script fetch engine
  output logic o_fetch_req,
  output logic [31:0] o_fetch_addr,
  output logic o_rw_start,
  output logic [31:0] o_rw_instr,
  // Table entry read port
  output logic o_mem_req,
  output logic [31:0] o_mem_addr,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_data,
  // SCSI bus sequencing
  input wire scsi_in_t i_scsi,
  output scsi_out_t o_scsi,
  output logic o_carry
);

  function automatic logic [31:0] sext24(input logic [31:0] v);
    sext24 = {{8{v[OFS_HI]}}, v[OFS_HI:0]};
  endfunction : sext24

  seq_state_t state;
  logic [31:0] cmd;
  logic [31:0] next_address_register;
  logic [31:0] data_structure_base;
  logic [31:0] script_pointer;
  logic [2:0] own_id_register;
  logic [7:0] control_register_zero;
  logic [7:0] control_register_three;
  logic [7:0] sync_transfer_register;
  logic [7:0] output_control_latch;
  logic signal_process_bit;
  logic illegal;
  logic [2:0] dest_id;
  logic go_alt;
  logic msg_seen;
  logic [6:0] free_cnt;
  logic atn_hold;

  logic apb_acc;
  logic wr_en;
  logic [2:0] opc;
  logic tgt_role;
  logic is_io;
  logic bad_atn;
  logic do_set;
  logic do_clr;
  logic bus_free_done;
  logic sel_evt;
  logic resel_evt;
  logic finish_seq;
  logic finish_alt;
  logic release_now;
  logic arb_win_now;
  logic [31:0] alt_target;
  logic [31:0] rd_mux;
  logic addr_ok;

  assign apb_acc = i_psel & i_penable & o_pready;
  assign wr_en = apb_acc & i_pwrite;
  assign opc = cmd[OPC_HI:OPC_LO];
  assign tgt_role = control_register_zero[CTRL0_TGT];
  assign is_io = (opc <= OP_CLR);
  assign bad_atn = cmd[SELATN_BIT] & ~((opc == OP_SEL) & ~tgt_role);
  assign do_set = (state == ST_DECODE) & (opc == OP_SET) & ~bad_atn;
  assign do_clr = (state == ST_DECODE) & (opc == OP_CLR) & ~bad_atn;
  assign sel_evt = i_scsi.selected;
  assign resel_evt = i_scsi.reselected;
  assign bus_free_done = (free_cnt >= BUS_FREE_CYC);
  assign arb_win_now = (state == ST_RUN) & (opc == OP_SEL) & i_scsi.arb_won
                       & ~sel_evt & ~resel_evt;
  assign release_now = (state == ST_RUN) & (opc == OP_DISC) & tgt_role;
  assign alt_target = cmd[REL_BIT] ? script_pointer + sext24(next_address_register)
                                   : next_address_register;

  // Completion conditions per instruction while running
  always_comb begin
    finish_seq = 1'b0;
    finish_alt = 1'b0;
    if (state == ST_RUN) begin
      case (opc)
        OP_SEL: begin
          if (sel_evt | resel_evt) begin
            finish_alt = 1'b1;
          end else if (i_scsi.arb_won) begin
            finish_seq = 1'b1;
          end
        end
        OP_DISC: begin
          if (tgt_role | (msg_seen & bus_free_done)) begin
            finish_seq = 1'b1;
          end
        end
        OP_WAIT: begin
          if (signal_process_bit) begin
            finish_alt = 1'b1;
          end else if (tgt_role) begin
            finish_seq = sel_evt;
            finish_alt = resel_evt & ~sel_evt;
          end else begin
            finish_alt = sel_evt;
            finish_seq = resel_evt & ~sel_evt;
          end
        end
        default: begin
          finish_seq = 1'b1;
        end
      endcase
    end
  end

  // Sequencer state
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= ST_IDLE;
      go_alt <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (wr_en && i_paddr == ADDR_CMD) begin
            state <= ST_DECODE;
          end
        end
        ST_DECODE: begin
          go_alt <= 1'b0;
          if (!is_io || bad_atn) begin
            state <= ST_IDLE;
          end else if (cmd[TBL_BIT] && (opc == OP_SEL || opc == OP_WAIT)) begin
            state <= ST_TABLE;
          end else if (opc == OP_SET || opc == OP_CLR) begin
            state <= ST_DONE;
          end else begin
            state <= ST_RUN;
          end
        end
        ST_TABLE: begin
          if (i_mem_ack) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (finish_alt) begin
            go_alt <= 1'b1;
            state <= ST_DONE;
          end else if (finish_seq) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Fetch engine hand-off
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_fetch_req <= 1'b0;
      o_fetch_addr <= RST_WORD;
      o_rw_start <= 1'b0;
      o_rw_instr <= RST_WORD;
    end else begin
      o_fetch_req <= (state == ST_DONE);
      if (state == ST_DONE) begin
        o_fetch_addr <= go_alt ? alt_target : script_pointer;
      end
      o_rw_start <= (state == ST_DECODE) & ~is_io;
      if (state == ST_DECODE && !is_io) begin
        o_rw_instr <= cmd;
      end
    end
  end

  // Table entry address: base plus signed offset
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_mem_req <= 1'b0;
      o_mem_addr <= RST_WORD;
    end else begin
      if (state == ST_DECODE) begin
        o_mem_addr <= data_structure_base + sext24(cmd);
      end
      o_mem_req <= (state == ST_DECODE && is_io && !bad_atn && cmd[TBL_BIT]
                    && (opc == OP_SEL || opc == OP_WAIT))
                   | (o_mem_req & ~i_mem_ack);
    end
  end

  // Destination ID and table-loaded configuration
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dest_id <= RST_ID;
      control_register_three <= RST_BYTE;
      sync_transfer_register <= RST_BYTE;
    end else begin
      if (state == ST_DECODE) begin
        dest_id <= cmd[ID_HI:ID_LO];
      end
      if (state == ST_TABLE && i_mem_ack) begin
        control_register_three <= i_mem_data[7:0];
        dest_id <= i_mem_data[10:8];
        sync_transfer_register <= i_mem_data[23:16];
      end else if (wr_en && i_paddr == ADDR_CTRL3) begin
        control_register_three <= i_pwdata[7:0];
      end else if (wr_en && i_paddr == ADDR_SYNC_TRANSFER_REGISTER) begin
        sync_transfer_register <= i_pwdata[7:0];
      end
    end
  end

  // Software-loaded instruction and pointer registers
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cmd <= RST_WORD;
      next_address_register <= RST_WORD;
      data_structure_base <= RST_WORD;
      script_pointer <= RST_WORD;
      own_id_register <= RST_ID;
    end else if (wr_en) begin
      case (i_paddr)
        ADDR_CMD: begin
          if (state == ST_IDLE) begin
            cmd <= i_pwdata;
          end
        end
        ADDR_NEXT: next_address_register <= i_pwdata;
        ADDR_DSB: data_structure_base <= i_pwdata;
        ADDR_DSP: script_pointer <= i_pwdata;
        ADDR_OWNID: own_id_register <= i_pwdata[2:0];
        default: begin
        end
      endcase
    end
  end

  // Latches touched by set and clear
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      output_control_latch <= RST_BYTE;
      control_register_zero <= RST_BYTE;
      o_carry <= 1'b0;
    end else begin
      if (do_set) begin
        // Ack bit 6, atn bit 3
        if (cmd[ACK_BIT]) output_control_latch[ACK_BIT] <= 1'b1;
        if (cmd[ATN_BIT]) output_control_latch[ATN_BIT] <= 1'b1;
        if (cmd[TGT_BIT]) control_register_zero[CTRL0_TGT] <= 1'b1;
        if (cmd[CARRY_BIT]) o_carry <= 1'b1;
      end else if (do_clr) begin
        if (cmd[ACK_BIT]) output_control_latch[ACK_BIT] <= 1'b0;
        if (cmd[ATN_BIT]) output_control_latch[ATN_BIT] <= 1'b0;
        if (cmd[TGT_BIT]) control_register_zero[CTRL0_TGT] <= 1'b0;
        if (cmd[CARRY_BIT]) o_carry <= 1'b0;
      end else if (release_now) begin
        output_control_latch <= RST_BYTE;
      end else if (wr_en && i_paddr == ADDR_OCL) begin
        output_control_latch <= i_pwdata[7:0];
      end else if (wr_en && i_paddr == ADDR_CTRL0) begin
        control_register_zero <= i_pwdata[7:0];
      end
    end
  end

  // Wait-disconnect message flag and bus-free timer
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      msg_seen <= 1'b0;
      free_cnt <= 7'h00;
    end else begin
      if (state != ST_RUN) begin
        msg_seen <= 1'b0;
      end else if (i_scsi.disc_msg) begin
        msg_seen <= 1'b1;
      end
      // Bus free for the full delay
      if (!msg_seen || i_scsi.busy_line || i_scsi.sel_line) begin
        free_cnt <= 7'h00;
      end else if (!bus_free_done) begin
        free_cnt <= free_cnt + 7'h01;
      end
    end
  end

  // Status: signal process, illegal instruction
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      signal_process_bit <= 1'b0;
      illegal <= 1'b0;
    end else begin
      if (wr_en && i_paddr == ADDR_INTERRUPT_STATUS_REGISTER && i_pwdata[ST_SIGNAL_PROCESS_BIT]) begin
        signal_process_bit <= 1'b1;
      end else if (state == ST_RUN && opc == OP_WAIT && signal_process_bit) begin
        signal_process_bit <= 1'b0;
      end
      // Illegal flag, set wins over clear
      if (state == ST_DECODE && is_io && bad_atn) begin
        illegal <= 1'b1;
      end else if (wr_en && i_paddr == ADDR_INTERRUPT_STATUS_REGISTER && i_pwdata[ST_ILLEGAL]) begin
        illegal <= 1'b0;
      end
    end
  end

  // SCSI bus request outputs
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_scsi <= '0;
      atn_hold <= 1'b0;
    end else begin
      if (arb_win_now && cmd[SELATN_BIT]) begin
        atn_hold <= 1'b1;
      end else if (i_scsi.sel_done || release_now) begin
        atn_hold <= 1'b0;
      end
      // Hold request until won, selected or reselected, losses ignored
      o_scsi.arb_req <= (state == ST_RUN) & (opc == OP_SEL) & ~finish_seq & ~finish_alt;
      o_scsi.arb_id <= own_id_register;
      o_scsi.sel_start <= arb_win_now;
      o_scsi.sel_id <= dest_id;
      // Initiator signals only in initiator role
      o_scsi.attention_line <= ~release_now
                               & (atn_hold | (arb_win_now & cmd[SELATN_BIT])
                                  | (output_control_latch[ATN_BIT] & ~tgt_role));
      o_scsi.acknowledge_line <= ~release_now
                                 & output_control_latch[ACK_BIT] & ~tgt_role;
      o_scsi.release_bus <= release_now;
    end
  end

  // APB read mux
  always_comb begin
    rd_mux = RST_WORD;
    addr_ok = 1'b1;
    case (i_paddr)
      ADDR_CMD: rd_mux = cmd;
      ADDR_NEXT: rd_mux = next_address_register;
      ADDR_DSB: rd_mux = data_structure_base;
      ADDR_DSP: rd_mux = script_pointer;
      ADDR_OWNID: rd_mux = {29'h0000_0000, own_id_register};
      ADDR_CTRL0: rd_mux = {24'h00_0000, control_register_zero};
      ADDR_CTRL3: rd_mux = {24'h00_0000, control_register_three};
      ADDR_SYNC_TRANSFER_REGISTER: rd_mux = {24'h00_0000, sync_transfer_register};
      ADDR_OCL: rd_mux = {24'h00_0000, output_control_latch};
      ADDR_INTERRUPT_STATUS_REGISTER: rd_mux = {28'h000_0000, o_carry, illegal, (state != ST_IDLE),
                            signal_process_bit};
      default: addr_ok = 1'b0;
    endcase
  end

  // APB answer: one wait state, error on unmapped address
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pready <= 1'b0;
      o_prdata <= RST_WORD;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel & i_penable & ~o_pready;
      if (i_psel && i_penable && !o_pready) begin
        o_prdata <= i_pwrite ? RST_WORD : rd_mux;
        o_pslverr <= ~addr_ok;
      end else begin
        o_pslverr <= 1'b0;
      end
    end
  end

endmodule : scsi_io_instruction_sequencer

`default_nettype wire

// ### verif/scsi_io_props.sv
// Port-level checker for the SCSI I/O instruction sequencer
`timescale 1ns/10ps
`default_nettype none
module scsi_io_props
  import scsi_io_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // APB
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Fetch and table port
  input wire logic o_fetch_req,
  input wire logic o_rw_start,
  input wire logic [31:0] o_rw_instr,
  input wire logic o_mem_req,
  input wire logic [31:0] o_mem_addr,
  input wire logic i_mem_ack,
  // SCSI
  input wire scsi_in_t i_scsi,
  input wire scsi_out_t o_scsi
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  property p_win;
    o_scsi.arb_req && i_scsi.arb_won && !i_scsi.selected && !i_scsi.reselected
      |=> o_scsi.sel_start && !o_scsi.arb_req ##1 o_fetch_req;
  endproperty
  a_win: assert property (p_win) else $error("win without select and fetch");
  property p_retry;
    o_scsi.arb_req && !i_scsi.arb_won && !i_scsi.selected && !i_scsi.reselected
      |=> o_scsi.arb_req;
  endproperty
  a_retry: assert property (p_retry) else $error("arbitration dropped");
  property p_pre;
    o_scsi.arb_req && (i_scsi.selected || i_scsi.reselected) |=> !o_scsi.sel_start;
  endproperty
  a_pre: assert property (p_pre) else $error("selection after being selected");
  property p_atn;
    o_scsi.sel_start && o_scsi.attention_line && !i_scsi.sel_done
      |=> o_scsi.attention_line [*2];
  endproperty
  a_atn: assert property (p_atn) else $error("attention dropped in selection");
  property p_rel;
    o_scsi.release_bus |-> ##[0:1] (!o_scsi.attention_line && !o_scsi.acknowledge_line
      && !o_scsi.arb_req && !o_scsi.sel_start);
  endproperty
  a_rel: assert property (p_rel) else $error("bus not released");
  property p_rw;
    o_rw_start |-> o_rw_instr[29:27] >= 3'h5 && !o_fetch_req;
  endproperty
  a_rw: assert property (p_rw) else $error("wrong opcode to read/write path");
  property p_mem;
    o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr);
  endproperty
  a_mem: assert property (p_mem) else $error("table read not held");
  property p_one;
    o_fetch_req |=> !o_fetch_req;
  endproperty
  a_one: assert property (p_one) else $error("fetch request longer than one cycle");
  property p_rdy;
    i_psel && $rose(i_penable) |=> o_pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready not after one wait state"); // APB timing
  property p_err;
    o_pslverr |-> o_pready;
  endproperty
  a_err: assert property (p_err) else $error("error without ready"); // APB timing
endmodule : scsi_io_props

bind scsi_io_instruction_sequencer scsi_io_props scsi_io_props_inst (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_fetch_req(o_fetch_req),
  .o_rw_start(o_rw_start), .o_rw_instr(o_rw_instr), .o_mem_req(o_mem_req),
  .o_mem_addr(o_mem_addr), .i_mem_ack(i_mem_ack), .i_scsi(i_scsi), .o_scsi(o_scsi)
);
`default_nettype wire

// ### verif/scsi_bus_partner.sv
// Far-side SCSI devices and table memory
`timescale 1ns/10ps
`default_nettype none
module scsi_bus_partner
  import scsi_io_pkg::*;
#(
  parameter logic [31:0] ENTRY = 32'h0044_0633
)
(
  // Clock, reset, scenario
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [2:0] i_mode,
  // Sequencer side
  input wire scsi_out_t i_scsi,
  input wire logic i_mem_req,
  output scsi_in_t o_scsi,
  output logic o_mem_ack,
  output logic [31:0] o_mem_data
);
  logic [7:0] cnt;
  logic [2:0] sd;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt <= 8'h00;
      sd <= 3'h0;
      o_scsi <= '0;
      o_mem_ack <= 1'b0;
      o_mem_data <= ~ENTRY;
    end else begin
      cnt <= (i_scsi.arb_req || i_mode == 3'h4) ? cnt + 8'h01 : 8'h00;
      sd <= {sd[1:0], i_scsi.sel_start};
      // Arbitration lost for three cycles, then won
      o_scsi.arb_won <= i_mode == 3'h1 && i_scsi.arb_req && cnt >= 8'h03;
      o_scsi.selected <= i_mode == 3'h2;
      o_scsi.reselected <= i_mode == 3'h3;
      o_scsi.sel_done <= sd[2];
      // Message while connected, then bus free
      o_scsi.busy_line <= i_mode == 3'h4 && cnt <= 8'h08;
      o_scsi.disc_msg <= i_mode == 3'h4 && cnt == 8'h08;
      // Short selection on the bus restarts the bus-free timing
      o_scsi.sel_line <= i_mode == 3'h4 && cnt == 8'h0C;
      o_mem_ack <= i_mem_req && !o_mem_ack;
      o_mem_data <= (i_mem_req && !o_mem_ack) ? ENTRY : ~o_mem_data;
    end
  end
endmodule : scsi_bus_partner
`default_nettype wire

// ### verif/tb_scsi_io_instruction_sequencer.sv
// Testbench for the SCSI I/O instruction sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_scsi_io_instruction_sequencer;
  import scsi_io_pkg::*;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] fetch_addr;
  logic [31:0] rw_instr;
  logic [31:0] mem_addr;
  logic [31:0] mem_data;
  logic [31:0] q;
  logic pready, pslverr, fetch_req, rw_start, mem_req, mem_ack, carry, err;
  logic [2:0] mode = 3'h0;
  logic [2:0] aid = 3'h0;
  scsi_in_t scsi_in;
  scsi_out_t scsi_out;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int n;

  scsi_io_instruction_sequencer scsi_io_instruction_sequencer_inst (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_fetch_req(fetch_req), .o_fetch_addr(fetch_addr),
    .o_rw_start(rw_start), .o_rw_instr(rw_instr), .o_mem_req(mem_req),
    .o_mem_addr(mem_addr), .i_mem_ack(mem_ack), .i_mem_data(mem_data),
    .i_scsi(scsi_in), .o_scsi(scsi_out), .o_carry(carry));
  scsi_bus_partner scsi_bus_partner_inst (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_mode(mode), .i_scsi(scsi_out),
    .i_mem_req(mem_req), .o_scsi(scsi_in), .o_mem_ack(mem_ack), .o_mem_data(mem_data));

  always #4 i_clk = ~i_clk;

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic run(input logic [31:0] cmd, input logic sp, input logic [31:0] exp);
    apb(1'b1, ADDR_CMD, cmd);
    if (sp) apb(1'b1, ADDR_INTERRUPT_STATUS_REGISTER, 32'h1);
    n = 0;
    while (fetch_req !== 1'b1 && n < 200) begin
      @(posedge i_clk);
      if (scsi_out.arb_req === 1'b1) aid = scsi_out.arb_id;
      n++;
    end
    chk(32'(fetch_req), 32'h1);
    chk(fetch_addr, exp);
  endtask : run

  function automatic logic [31:0] io(input logic [2:0] op, input logic [26:0] f);
    return {2'b01, op, f};
  endfunction : io

  function automatic logic [31:0] lines();
    return {30'h0, scsi_out.attention_line, scsi_out.acknowledge_line};
  endfunction : lines

  initial begin
    repeat (10) @(posedge i_clk);
    i_nrst <= 1'b1;
    apb(1'b0, ADDR_INTERRUPT_STATUS_REGISTER, 32'h0);
    chk(q, 32'h0);
    chk(32'(carry), 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk({err, q[30:0]}, 32'h8000_0000);
    $display("Test reset and map finished");
    apb(1'b1, ADDR_OWNID, 32'h3);
    apb(1'b1, ADDR_DSP, 32'h100);
    apb(1'b1, ADDR_NEXT, 32'h800);
    apb(1'b1, ADDR_DSB, 32'h1000);
    run(io(OP_SET, 27'h448), 1'b0, 32'h100);
    apb(1'b0, ADDR_OCL, 32'h0);
    chk(q, 32'h48);
    chk(lines(), 32'h3);
    chk(32'(carry), 32'h1);
    run(io(OP_CLR, 27'h40), 1'b0, 32'h100);
    apb(1'b0, ADDR_OCL, 32'h0);
    chk(q, 32'h08);
    run(io(OP_CLR, 27'h408), 1'b0, 32'h100);
    chk(32'(carry), 32'h0);
    chk(lines(), 32'h0);
    $display("Test set and clear finished");
    run(io(OP_SET, 27'h200), 1'b0, 32'h100);
    apb(1'b0, ADDR_CTRL0, 32'h0);
    chk(q, 32'h1);
    run(io(OP_SET, 27'h40), 1'b0, 32'h100);
    apb(1'b0, ADDR_OCL, 32'h0);
    chk(q, 32'h40);
    chk(lines(), 32'h0);
    run(io(OP_DISC, 27'h0), 1'b0, 32'h100);
    apb(1'b0, ADDR_OCL, 32'h0);
    chk(q, 32'h0);
    mode <= 3'h3;
    run(io(OP_WAIT, 27'h0), 1'b0, 32'h800);
    mode <= 3'h2;
    run(io(OP_WAIT, 27'h0), 1'b0, 32'h100);
    mode <= 3'h1;
    run(io(OP_SEL, 27'h2_0000), 1'b0, 32'h100);
    chk(32'(scsi_out.sel_id), 32'h2);
    chk(32'(aid), 32'h3);
    apb(1'b0, ADDR_INTERRUPT_STATUS_REGISTER, 32'h0);
    chk(q, 32'h0);
    run(io(OP_CLR, 27'h200), 1'b0, 32'h100);
    $display("Test target role finished");
    run(io(OP_SEL, 27'h105_0000), 1'b0, 32'h100);
    chk(32'(scsi_out.sel_id), 32'h5);
    chk(32'(scsi_out.attention_line), 32'h1);
    apb(1'b1, ADDR_NEXT, 32'h00FF_FFF0);
    mode <= 3'h2;
    run(io(OP_SEL, 27'h400_0000), 1'b0, 32'h0F0);
    mode <= 3'h1;
    run(io(OP_SEL, 27'h6FF_FFF8), 1'b0, 32'h100);
    chk(mem_addr, 32'h0FF8);
    chk(32'(scsi_out.sel_id), 32'h6);
    apb(1'b0, ADDR_CTRL3, 32'h0);
    chk(q, 32'h33);
    apb(1'b0, ADDR_SYNC_TRANSFER_REGISTER, 32'h0);
    chk(q, 32'h44);
    mode <= 3'h3;
    run(io(OP_SEL, 27'h200_0010), 1'b0, 32'h00FF_FFF0);
    chk(mem_addr, 32'h1010);
    run(io(OP_WAIT, 27'h0), 1'b0, 32'h100);
    mode <= 3'h2;
    run(io(OP_WAIT, 27'h0), 1'b0, 32'h00FF_FFF0);
    mode <= 3'h0;
    run(io(OP_WAIT, 27'h0), 1'b1, 32'h00FF_FFF0);
    mode <= 3'h4;
    run(io(OP_DISC, 27'h0), 1'b0, 32'h100);
    chk(32'(n >= 63 && n <= 65), 32'h1);
    mode <= 3'h0;
    $display("Test initiator role finished");
    apb(1'b1, ADDR_CMD, 32'h6912_3456);
    n = 0;
    while (rw_start !== 1'b1 && n < 20) begin
      @(posedge i_clk);
      n++;
    end
    chk(rw_instr, 32'h6912_3456);
    repeat (6) @(posedge i_clk);
    apb(1'b1, ADDR_CMD, io(OP_SET, 27'h100_0008));
    repeat (6) @(posedge i_clk);
    apb(1'b0, ADDR_INTERRUPT_STATUS_REGISTER, 32'h0);
    chk(q & 32'h6, 32'h4);
    apb(1'b0, ADDR_OCL, 32'h0);
    chk(q, 32'h0);
    $display("Test read/write and illegal finished");
    complete_run();
  end
endmodule : tb_scsi_io_instruction_sequencer
`default_nettype wire
